// ---- core/atsc_cfg_mem.sv ----
// stored source configurations, one entry per saved setup file
// assumes one clock; read data appear one edge after the address
`timescale 1ns/100ps
`default_nettype none
module atsc_cfg_mem
   import atsc_pkg::*;
#(
   parameter int DEPTH = SAVED_DEPTH,
   parameter int AW = SAVED_AW,
   parameter int DW = ENTRY_W
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem_r [DEPTH]; // entries, flops so reset gives internal
   logic [DW-1:0] mem_nxt [DEPTH];
   logic [DW-1:0] rd_r; // registered read port
   logic [DW-1:0] rd_nxt;

   // next contents and read word
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         mem_nxt[i] = mem_r[i];
         if (wr_en_in && (wr_addr_in == AW'(i)))
            mem_nxt[i] = wr_data_in;
      end
      rd_nxt = ENTRY_RESET; // out of range reads give the reset entry
      for (int i = 0; i < DEPTH; i++)
         if (rd_addr_in == AW'(i))
            rd_nxt = mem_r[i];
   end

   // register only
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_r[i] <= ENTRY_RESET;
         rd_r <= ENTRY_RESET;
      end
      else
      begin
         mem_r <= mem_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign rd_data_out = rd_r;
endmodule : atsc_cfg_mem
`default_nettype wire

// ---- core/atsc_core.sv ----
// ambient temperature source command handler with axi4-lite registers
// assumes a same-clock sensor value in hundredths of a degree C
// Operation
// - setup index must be one through twenty-one
// - setup twenty-one kept apart, remote only
// - source only internal, default or user
// - internal sensor, user value, maker default
// - meas argument allowed only with user
// - user meas in celsius, zero to fifty
// - stored and reported value in celsius
// - nineteen saved source configurations kept
// - setup one fixed internal, changes refused
// - set with value, set, or query
// - every reply holds source and value
// - errors one setup, two source, three meas
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module atsc_core
   import atsc_pkg::*;
#(
   parameter logic [15:0] DEFAULT_TEMP = 16'h07d0 // maker fixed value, 20.00 C
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [15:0] sensor_temp_in, // hundredths degree C
   input wire logic [4:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [4:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic irq_out
);
   // ********************************
   // helpers
   // ********************************
   // byte-lane merge, used by the command and mask words
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            res[b*8 +: 8] = new_v[b*8 +: 8];
      return res;
   endfunction : strb_merge

   // ********************************
   // axi write channel
   // ********************************
   logic aw_held_r, aw_held_nxt; // address taken, waiting for data
   logic w_held_r, w_held_nxt; // data taken, waiting for address
   logic [4:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic wr_fire; // both halves present, write happens now
   logic wr_mapped;

   assign s_axi_awready_out = !aw_held_r && !bvalid_r;
   assign s_axi_wready_out = !w_held_r && !bvalid_r;
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
   assign wr_mapped = (awaddr_r == OFF_CMD) || (awaddr_r == OFF_GO) || (awaddr_r == OFF_STAT)
                      || (awaddr_r == OFF_MASK);

   // address and data accepted in either order
   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_in;
         wstrb_nxt = s_axi_wstrb_in;
      end
      if (wr_fire)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_mapped ? RESP_OKAY : RESP_SLVERR; // reply word is read only
      end
      else if (bvalid_r && s_axi_bready_in)
         bvalid_nxt = 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 5'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;

   // ********************************
   // control, command engine, status
   // ********************************
   logic [31:0] cmd_r, cmd_nxt; // software command word
   logic [31:0] act_r, act_nxt; // snapshot taken at start
   logic [STAT_W-1:0] stat_r, stat_nxt;
   logic [STAT_W-1:0] mask_r, mask_nxt;
   logic [31:0] reply_r, reply_nxt;
   logic [ENTRY_W-1:0] remote_r, remote_nxt; // remote-only setup, not in the file store
   atsc_state_e state_r, state_nxt;
   logic irq_r, irq_nxt;
   logic start; // go written while idle
   logic [4:0] a_setup;
   atsc_src_e a_src;
   logic a_hasm, a_set;
   logic [15:0] a_meas;
   logic [ENTRY_W-1:0] mem_rd, cur_entry, new_entry;
   atsc_err_e err;
   logic mem_wr, remote_wr, exec;
   atsc_src_e rep_src;
   logic [15:0] rep_val;
   logic [SAVED_AW-1:0] mem_addr;

   assign a_setup = act_r[CMD_SETUP_LSB +: 5];
   assign a_src = atsc_src_e'(act_r[CMD_SRC_LSB +: 2]);
   assign a_hasm = act_r[CMD_HASM_BIT];
   assign a_set = act_r[CMD_SET_BIT];
   assign a_meas = act_r[CMD_MEAS_LSB +: 16];
   assign exec = (state_r == ST_EXEC);
   assign start = wr_fire && (awaddr_r == OFF_GO) && wstrb_r[0] && wdata_r[GO_BIT]
                  && (state_r == ST_IDLE); // go while busy is dropped
   assign mem_addr = SAVED_AW'(a_setup - SETUP_FIRST_SAVED);

   // current stored entry of the addressed setup
   always_comb
   begin
      if (a_setup == SETUP_FIXED)
         cur_entry = ENTRY_RESET;
      else if (a_setup == SETUP_REMOTE)
         cur_entry = remote_r;
      else
         cur_entry = mem_rd;
   end

   // argument checks, first failing check names the error
   always_comb
   begin
      err = ERR_NONE;
      if ((a_setup < SETUP_MIN) || (a_setup > SETUP_MAX))
         err = ERR_SETUP;
      else if (a_set && (a_src == SRC_BAD))
         err = ERR_SOURCE;
      else if (a_set && (a_setup == SETUP_FIXED) && (a_src != SRC_INTERNAL))
         err = ERR_SOURCE;
      else if (a_set && a_hasm && (a_src != SRC_USER))
         err = ERR_MEAS;
      else if (a_set && a_hasm && (a_meas > MEAS_MAX))
         err = ERR_MEAS;
   end

   // new entry; source-only user set keeps the stored user value
   always_comb
   begin
      new_entry = {a_src, cur_entry[15:0]};
      if (a_hasm)
         new_entry = {a_src, a_meas};
      mem_wr = exec && a_set && (err == ERR_NONE) && (a_setup != SETUP_FIXED)
               && (a_setup != SETUP_REMOTE);
      remote_wr = exec && a_set && (err == ERR_NONE) && (a_setup == SETUP_REMOTE);
   end

   // reply always gives source and value; refused commands report stored state
   always_comb
   begin
      rep_src = atsc_src_e'(cur_entry[17:16]);
      if (a_set && (err == ERR_NONE))
         rep_src = atsc_src_e'(new_entry[17:16]);
      case (rep_src)
         SRC_INTERNAL: rep_val = sensor_temp_in;
         SRC_DEFAULT: rep_val = DEFAULT_TEMP;
         SRC_USER: rep_val = (a_set && (err == ERR_NONE)) ? new_entry[15:0] : cur_entry[15:0];
         default: rep_val = 16'h0000;
      endcase
   end

   // registers, command sequence and events
   always_comb
   begin
      cmd_nxt = cmd_r;
      mask_nxt = mask_r;
      act_nxt = act_r;
      reply_nxt = reply_r;
      remote_nxt = remote_r;
      state_nxt = state_r;
      stat_nxt = stat_r;
      if (wr_fire && (awaddr_r == OFF_CMD))
         cmd_nxt = strb_merge(cmd_r, wdata_r, wstrb_r);
      if (wr_fire && (awaddr_r == OFF_MASK))
         mask_nxt = STAT_W'(strb_merge(32'(mask_r), wdata_r, wstrb_r));
      if (wr_fire && (awaddr_r == OFF_STAT) && wstrb_r[0])
         stat_nxt = stat_r & ~wdata_r[STAT_W-1:0];
      case (state_r)
         ST_IDLE:
         begin
            if (start)
            begin
               act_nxt = cmd_r;
               state_nxt = ST_FETCH;
            end
         end
         ST_FETCH: state_nxt = ST_EXEC; // store read in flight
         ST_EXEC:
         begin
            reply_nxt = 32'h0000_0000;
            reply_nxt[REP_SRC_LSB +: 2] = rep_src;
            reply_nxt[REP_ERR_LSB +: 2] = err;
            reply_nxt[REP_VAL_LSB +: 16] = rep_val;
            if (remote_wr)
               remote_nxt = new_entry;
            stat_nxt[STAT_DONE_BIT] = 1'b1; // set wins over a same-cycle clear
            if (err != ERR_NONE)
               stat_nxt[STAT_ERR_BIT] = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cmd_r <= 32'h0000_0000;
         act_r <= 32'h0000_0000;
         mask_r <= '0;
         stat_r <= '0;
         reply_r <= 32'h0000_0000;
         remote_r <= ENTRY_RESET;
         state_r <= ST_IDLE;
         irq_r <= 1'b0;
      end
      else
      begin
         cmd_r <= cmd_nxt;
         act_r <= act_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         reply_r <= reply_nxt;
         remote_r <= remote_nxt;
         state_r <= state_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq_out = irq_r;

   // saved setup files, setups two to twenty
   atsc_cfg_mem u_mem (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(mem_wr),
      .wr_addr_in(mem_addr),
      .wr_data_in(new_entry),
      .rd_addr_in(mem_addr),
      .rd_data_out(mem_rd)
   );

   // ********************************
   // axi read channel
   // ********************************
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   assign s_axi_arready_out = !rvalid_r;

   // decode on acceptance, hold until taken
   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         case (s_axi_araddr_in)
            OFF_CMD: rdata_nxt = cmd_r;
            OFF_GO: rdata_nxt[GO_BIT] = (state_r != ST_IDLE);
            OFF_REPLY: rdata_nxt = reply_r;
            OFF_STAT: rdata_nxt[STAT_W-1:0] = stat_r;
            OFF_MASK: rdata_nxt[STAT_W-1:0] = mask_r;
            default: rresp_nxt = RESP_SLVERR;
         endcase
      end
      else if (rvalid_r && s_axi_rready_in)
         rvalid_nxt = 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out = rdata_r;
   assign s_axi_rresp_out = rresp_r;

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   bvalid_hold_a: assert property (bvalid_r && !s_axi_bready_in |=> bvalid_r)
      else $error("write response dropped before taken");
   cmd_seq_a: assert property (start |=> (state_r == ST_FETCH) ##1 exec ##1 stat_r[STAT_DONE_BIT])
      else $error("command did not finish in three cycles");
   setup_range_a: assert property (exec && ((a_setup == 5'h00) || (a_setup > SETUP_MAX))
      |=> reply_r[REP_ERR_LSB +: 2] == ERR_SETUP)
      else $error("bad setup index not answered with error one");
   fixed_setup_a: assert property (exec && (a_setup == SETUP_FIXED) |-> !mem_wr && !remote_wr)
      else $error("setup one store written");
   remote_apart_a: assert property (exec && (a_setup == SETUP_REMOTE) |-> !mem_wr)
      else $error("remote setup written to file store");
   meas_limit_a: assert property ((mem_wr || remote_wr) && a_hasm
      |-> (a_src == SRC_USER) && (a_meas <= MEAS_MAX))
      else $error("meas stored out of range or without user");
   err_keep_a: assert property (exec && (err != ERR_NONE) |=> $stable(remote_r) && stat_r[STAT_ERR_BIT])
      else $error("refused command changed state or set no error");
   internal_val_a: assert property (exec && (rep_src == SRC_INTERNAL)
      |=> reply_r[REP_VAL_LSB +: 16] == $past(sensor_temp_in))
      else $error("internal source reply not sensor value");
   // status, mask and irq all load from their next values at one edge, so they agree every cycle
   irq_level_a: assert property (irq_out == (|(stat_r & mask_r)))
      else $error("interrupt does not follow masked status");

   user_set_c: cover property (remote_wr && a_hasm);
   meas_err_c: cover property (exec && (err == ERR_MEAS));
   query_c: cover property (exec && !a_set && (a_setup > SETUP_FIXED));
   file_write_c: cover property (mem_wr);
endmodule : atsc_core
`default_nettype wire

// ---- core/atsc_pkg.sv ----
// package of the ambient temperature source command block
// assumes one 125 MHz clock and an axi4-lite master with 32-bit data
package atsc_pkg;
   // ********************************
   // register byte offsets
   // ********************************
   localparam logic [4:0] OFF_CMD = 5'h00; // command word
   localparam logic [4:0] OFF_GO = 5'h04; // start / busy
   localparam logic [4:0] OFF_REPLY = 5'h08; // reply word
   localparam logic [4:0] OFF_STAT = 5'h0c; // sticky events, write one to clear
   localparam logic [4:0] OFF_MASK = 5'h10; // interrupt mask
   // ********************************
   // field positions
   // ********************************
   localparam int CMD_SETUP_LSB = 0; // setup index, 5 bits
   localparam int CMD_SRC_LSB = 5; // source keyword code, 2 bits
   localparam int CMD_HASM_BIT = 7; // meas argument present
   localparam int CMD_SET_BIT = 8; // 1 = set form, 0 = bare query
   localparam int CMD_MEAS_LSB = 16; // meas in hundredths of a degree C
   localparam int REP_SRC_LSB = 0; // reply source code
   localparam int REP_ERR_LSB = 2; // reply error number
   localparam int REP_VAL_LSB = 16; // reply value, hundredths degree C
   localparam int GO_BIT = 0; // start bit / busy bit
   localparam int STAT_DONE_BIT = 0; // command finished
   localparam int STAT_ERR_BIT = 1; // command refused
   localparam int STAT_W = 2;
   // ********************************
   // setup and value limits
   // ********************************
   localparam logic [4:0] SETUP_MIN = 5'h01;
   localparam logic [4:0] SETUP_MAX = 5'h15; // 21
   localparam logic [4:0] SETUP_FIXED = 5'h01; // locked to internal sensor
   localparam logic [4:0] SETUP_REMOTE = 5'h15; // remote-only setup
   localparam logic [4:0] SETUP_FIRST_SAVED = 5'h02;
   localparam int SAVED_DEPTH = 19; // saved setup files
   localparam int SAVED_AW = 5;
   localparam logic [15:0] MEAS_MAX = 16'h1388; // 50.00 degrees C
   localparam logic [15:0] MEAS_RESET = 16'h0000;
   localparam int ENTRY_W = 18; // {source, meas}
   // ********************************
   // types and bus answers
   // ********************************
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'b00,
      SRC_DEFAULT = 2'b01,
      SRC_USER = 2'b10,
      SRC_BAD = 2'b11
   } atsc_src_e;
   typedef enum logic [1:0] {
      ERR_NONE = 2'b00,
      ERR_SETUP = 2'b01,
      ERR_SOURCE = 2'b10,
      ERR_MEAS = 2'b11
   } atsc_err_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b10
   } atsc_state_e;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [ENTRY_W-1:0] ENTRY_RESET = {SRC_INTERNAL, MEAS_RESET};
endpackage : atsc_pkg

// ---- verif/atsc_host_model.sv ----
// axi4-lite master standing in for the remote host that sends commands
// assumes one clock; each task waits for a rising edge before it drives
`timescale 1ns/100ps
`default_nettype none
module atsc_host_model
(
   input wire logic clk_in,
   output logic [4:0] awaddr_out,
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [31:0] wdata_out,
   output logic [3:0] wstrb_out,
   output logic wvalid_out,
   input wire logic wready_in,
   input wire logic [1:0] bresp_in,
   input wire logic bvalid_in,
   output logic bready_out,
   output logic [4:0] araddr_out,
   output logic arvalid_out,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in,
   output logic rready_out
);
   // ***************************************
   // idle levels
   // ***************************************
   initial
   begin
      awaddr_out = 5'h00;
      awvalid_out = 1'h0;
      wdata_out = 32'h0000_0000;
      wstrb_out = 4'hf; // whole words only
      wvalid_out = 1'h0;
      bready_out = 1'h0;
      araddr_out = 5'h00;
      arvalid_out = 1'h0;
      rready_out = 1'h0;
   end
   // ***************************************
   // bus cycles
   // ***************************************
   // decide at the falling edge what the next rising edge takes, act after it
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      logic tb;
      @(posedge clk_in);
      awaddr_out <= a;
      wdata_out <= d;
      awvalid_out <= 1'h1;
      wvalid_out <= 1'h1;
      bready_out <= 1'h1;
      forever
      begin
         @(negedge clk_in);
         ta = awvalid_out && awready_in;
         tw = wvalid_out && wready_in;
         tb = bvalid_in;
         r = bresp_in;
         @(posedge clk_in);
         // released lines show the inverse so stale values never pass
         if (ta)
         begin
            awvalid_out <= 1'h0;
            awaddr_out <= ~a;
         end
         if (tw)
         begin
            wvalid_out <= 1'h0;
            wdata_out <= ~d;
         end
         if (tb)
         begin
            bready_out <= 1'h0;
            break;
         end
      end
   endtask : wr
   // read: address held until taken, rready held until rvalid
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tr;
      @(posedge clk_in);
      araddr_out <= a;
      arvalid_out <= 1'h1;
      rready_out <= 1'h1;
      forever
      begin
         @(negedge clk_in);
         ta = arvalid_out && arready_in;
         tr = rvalid_in;
         d = rdata_in;
         r = rresp_in;
         @(posedge clk_in);
         if (ta)
         begin
            arvalid_out <= 1'h0;
            araddr_out <= ~a;
         end
         if (tr)
         begin
            rready_out <= 1'h0;
            break;
         end
      end
   endtask : rd
endmodule : atsc_host_model
`default_nettype wire

// ---- verif/test_ambient_temp_source_cmd.sv ----
// self-checking bench of the ambient temperature source command block
// assumes the host model drives every axi4-lite channel of the core
`timescale 1ns/100ps
`default_nettype none
module test_ambient_temp_source_cmd;
   import atsc_pkg::*;
   // ***************************************
   // constants and wiring
   // ***************************************
   localparam logic [15:0] SENS_A = 16'h0910; // 23.20 c
   localparam logic [15:0] SENS_B = 16'h0a28; // 26.00 c
   localparam logic [15:0] DEF_T = 16'h07d0; // maker value, arbitrary
   localparam logic [15:0] U22 = 16'h0898; // 22.00 c
   localparam logic [31:0] FULL = 32'hffff_000f; // value, error, source
   localparam logic [31:0] ERRO = 32'h0000_000c; // error field only
   localparam int LIMIT = 20000; // far above the expected run
   logic clk_in;
   logic rst_n_in;
   logic [15:0] sensor_temp_in;
   logic [4:0] awaddr;
   logic awvalid;
   logic awready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wvalid;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready;
   logic [4:0] araddr;
   logic arvalid;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready;
   logic irq_out;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   atsc_core #(.DEFAULT_TEMP(DEF_T)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .sensor_temp_in(sensor_temp_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .irq_out(irq_out));
   atsc_host_model host (.clk_in(clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
      .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
      .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
      .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
      .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
   // ***************************************
   // clock and hang guard
   // ***************************************
   initial
   begin
      clk_in = 1'h0;
      forever #4 clk_in = ~clk_in;
   end
   // a run that hangs ends as a failure
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         mismatches++;
         test_done();
      end
   end
   // ***************************************
   // checking tasks
   // ***************************************
   task automatic test_done();
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // plain register access with expected response and masked data
   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host.wr(a, d, r);
      cmp({30'h0, r}, {30'h0, er});
   endtask : reg_wr
   task automatic reg_rd(input logic [4:0] a, input logic [1:0] er, input logic [31:0] m,
      input logic [31:0] ed);
      logic [31:0] d;
      logic [1:0] r;
      host.rd(a, d, r);
      cmp({30'h0, r}, {30'h0, er});
      cmp(d & m, ed);
   endtask : reg_rd
   // one command: load, start, wait idle, check reply, status and irq, clear
   task automatic run(input logic [4:0] s, input logic [1:0] src, input logic hm, input logic st,
      input logic [15:0] ms, input logic [1:0] es, input logic [1:0] ee, input logic [15:0] ev,
      input logic [31:0] m);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      host.wr(OFF_CMD, {ms, 7'h00, st, hm, src, s}, r);
      host.wr(OFF_GO, 32'h0000_0001, r);
      n = 0;
      do
      begin
         host.rd(OFF_GO, d, r);
         n++;
      end
      while (d[GO_BIT] !== 1'h0 && n < 50);
      cmp({31'h0, d[GO_BIT]}, 32'h0);
      host.rd(OFF_REPLY, d, r);
      cmp(d & m, {ev, 12'h000, ee, es} & m);
      host.rd(OFF_STAT, d, r);
      cmp({30'h0, d[1:0]}, {30'h0, ee != ERR_NONE, 1'h1});
      // only the error event is unmasked
      cmp({31'h0, irq_out}, {31'h0, ee != ERR_NONE});
      host.wr(OFF_STAT, 32'h0000_0003, r);
   endtask : run
   // ***************************************
   // main sequence
   // ***************************************
   initial
   begin
      rst_n_in = 1'h0;
      sensor_temp_in = SENS_A;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      reg_rd(OFF_MASK, RESP_OKAY, 32'h3, 32'h0);
      reg_rd(OFF_STAT, RESP_OKAY, 32'h3, 32'h0);
      reg_wr(5'h14, 32'h0000_0003, RESP_SLVERR);
      reg_wr(OFF_REPLY, 32'hffff_ffff, RESP_SLVERR);
      reg_rd(5'h14, RESP_SLVERR, 32'hffff_ffff, 32'h0);
      reg_wr(OFF_MASK, 32'h0000_0002, RESP_OKAY);
      reg_rd(OFF_MASK, RESP_OKAY, 32'h3, 32'h2);
      run(5'h02, SRC_INTERNAL, 1'h0, 1'h0, 16'h0, SRC_INTERNAL, ERR_NONE, SENS_A, FULL);
      run(5'h02, SRC_USER, 1'h1, 1'h1, U22, SRC_USER, ERR_NONE, U22, FULL);
      run(5'h02, SRC_INTERNAL, 1'h0, 1'h0, 16'h0, SRC_USER, ERR_NONE, U22, FULL);
      run(5'h03, SRC_DEFAULT, 1'h0, 1'h1, 16'h0, SRC_DEFAULT, ERR_NONE, DEF_T, FULL);
      run(5'h00, SRC_INTERNAL, 1'h0, 1'h0, 16'h0, SRC_INTERNAL, ERR_SETUP, 16'h0, ERRO);
      run(5'h16, SRC_USER, 1'h1, 1'h1, U22, SRC_INTERNAL, ERR_SETUP, 16'h0, ERRO);
      run(5'h15, SRC_USER, 1'h1, 1'h1, MEAS_MAX, SRC_USER, ERR_NONE, MEAS_MAX, FULL);
      run(5'h15, SRC_USER, 1'h1, 1'h1, MEAS_MAX + 16'h1, SRC_USER, ERR_MEAS, MEAS_MAX, FULL);
      run(5'h02, SRC_BAD, 1'h0, 1'h1, 16'h0, SRC_USER, ERR_SOURCE, U22, FULL);
      run(5'h03, SRC_DEFAULT, 1'h1, 1'h1, U22, SRC_DEFAULT, ERR_MEAS, DEF_T, FULL);
      run(5'h01, SRC_USER, 1'h1, 1'h1, U22, SRC_INTERNAL, ERR_SOURCE, SENS_A, FULL);
      run(5'h01, SRC_INTERNAL, 1'h0, 1'h1, 16'h0, SRC_INTERNAL, ERR_NONE, SENS_A, FULL);
      run(5'h14, SRC_USER, 1'h0, 1'h1, 16'h0, SRC_USER, ERR_NONE, 16'h0, FULL);
      run(5'h15, SRC_INTERNAL, 1'h0, 1'h0, 16'h0, SRC_USER, ERR_NONE, MEAS_MAX, FULL);
      run(5'h02, SRC_USER, 1'h1, 1'h1, 16'h0, SRC_USER, ERR_NONE, 16'h0, FULL);
      @(posedge clk_in);
      sensor_temp_in <= SENS_B;
      run(5'h01, SRC_INTERNAL, 1'h0, 1'h0, 16'h0, SRC_INTERNAL, ERR_NONE, SENS_B, FULL);
      repeat (2) @(posedge clk_in);
      cmp({31'h0, irq_out}, 32'h0);
      test_done();
   end
endmodule : test_ambient_temp_source_cmd
`default_nettype wire
